/* File: dsf_pkg.sv */
// package: assignment codes, fault groups, scalings and timing counts for the status flags
package dsf_pkg;
	// fault group reported by the protective logic
	typedef enum logic [4:0] {
		DSF_GRP_NONE, DSF_GRP_OVERCURRENT, DSF_GRP_OVERVOLT, DSF_GRP_UNDERVOLT,
		DSF_GRP_MOTOR_OVERLOAD, DSF_GRP_DRIVE_OVERLOAD, DSF_GRP_OVERHEAT,
		DSF_GRP_EXT_ALARM, DSF_GRP_MEMORY, DSF_GRP_COMM, DSF_GRP_OPTION,
		DSF_GRP_CIRCUIT, DSF_GRP_TUNING, DSF_GRP_SERIAL, DSF_GRP_SPEED,
		DSF_GRP_OTHER
	} dsf_group_t;

	// alarm codes per group (binary weighted 1/2/4/8)
	localparam logic [3:0] CODE_NONE = 4'h0;
	localparam logic [3:0] CODE_OVERCURRENT = 4'h1;
	localparam logic [3:0] CODE_OVERVOLT = 4'h2;
	localparam logic [3:0] CODE_UNDERVOLT = 4'h3;
	localparam logic [3:0] CODE_MOTOR_OVERLOAD = 4'h4;
	localparam logic [3:0] CODE_DRIVE_OVERLOAD = 4'h5;
	localparam logic [3:0] CODE_OVERHEAT = 4'h6;
	localparam logic [3:0] CODE_EXT_ALARM = 4'h7;
	localparam logic [3:0] CODE_MEMORY = 4'h8;
	localparam logic [3:0] CODE_COMM = 4'h9;
	localparam logic [3:0] CODE_OPTION = 4'ha;
	localparam logic [3:0] CODE_CIRCUIT = 4'hb;
	localparam logic [3:0] CODE_TUNING = 4'hc;
	localparam logic [3:0] CODE_SERIAL = 4'hd;
	localparam logic [3:0] CODE_SPEED = 4'he;
	localparam logic [3:0] CODE_OTHER = 4'hf;

	// assignment values selecting a flag onto a terminal
	localparam logic [7:0] SEL_SPEED_ARRIVE = 8'h01;
	localparam logic [7:0] SEL_FREQ_OVER = 8'h02;
	localparam logic [7:0] SEL_OVERLOAD_WARN = 8'h07;
	localparam logic [7:0] SEL_ARRIVE_DELAYED = 8'h15;
	localparam logic [7:0] SEL_FREQ_OVER_SECOND = 8'h1f;
	localparam logic [7:0] SEL_CURRENT_HIGH = 8'h25;
	localparam logic [7:0] SEL_CURRENT_HIGH_SECOND = 8'h26;
	localparam logic [7:0] SEL_CURRENT_HIGH_THIRD = 8'h27;
	localparam logic [7:0] SEL_CURRENT_LOW = 8'h29;
	localparam logic [7:0] SEL_ARRIVE_ZERO_REF = 8'h48;
	localparam logic [7:0] SEL_FREQ_OVER_THIRD = 8'h3a;
	localparam logic [7:0] SEL_CODE_W1 = 8'h5a;
	localparam logic [7:0] SEL_CODE_W2 = 8'h5b;
	localparam logic [7:0] SEL_CODE_W4 = 8'h5c;
	localparam logic [7:0] SEL_CODE_W8 = 8'h5d;
	localparam logic [7:0] SEL_LIGHT_FAULT = 8'h62;
	localparam logic [7:0] SEL_ANY_FAULT = 8'h63;
	localparam logic [7:0] SEL_ENABLE_CIRCUIT = 8'h65;
	localparam logic [7:0] SEL_ENABLE_OFF = 8'h66;
	localparam logic [7:0] SEL_BRAKE_SWITCH = 8'h69;
	localparam logic [7:0] SEL_CUSTOM_FIRST = 8'h6f;
	localparam logic [7:0] SEL_CUSTOM_LAST = 8'h78;

	// frequencies in 0.1 Hz units, currents in 0.1 % of rated current
	localparam logic [15:0] ARRIVE_WIDTH_MAX = 16'h0064;
	localparam logic [15:0] FREQ_SETTING_MAX = 16'h1388;
	localparam logic [15:0] RATED_5PCT = 16'h0032;
	// timers in 10 ms units: delay 0.01..10.00 s, current timer 0.00..600.00 s
	localparam logic [15:0] ARRIVE_DELAY_MIN = 16'h0001;
	localparam logic [15:0] ARRIVE_DELAY_MAX = 16'h03e8;
	localparam logic [15:0] CURRENT_TIMER_MAX = 16'hea60;
	// thermal time constant range, 0.1 min units (used by the thermal model outside)
	localparam logic [15:0] THERMAL_TC_MIN = 16'h0005;
	localparam logic [15:0] THERMAL_TC_MAX = 16'h02ee;

	localparam int CLK_HZ = 100000000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int MIN_ON_MS = 100;
	localparam int MIN_ON_TICKS = MIN_ON_MS / TICK_MS;
	localparam int TERMINALS = 5;

	// fault inputs from the protective logic
	typedef struct packed {
		dsf_group_t group;
		logic tripped;
		logic light_alarm;
		logic enable_circuit_error;
		logic enable_terminal_on;
		logic brake_switch_broken;
	} dsf_fault_t;

	// measurements
	typedef struct packed {
		logic run_cmd;
		logic [15:0] ref_freq;
		logic [15:0] out_freq;
		logic [15:0] pre_limit_freq;
		logic [15:0] out_current;
	} dsf_meas_t;

	// settings
	typedef struct packed {
		logic [15:0] arrive_width_setting;
		logic [15:0] arrive_delay_setting;
		logic [15:0] freq_level_setting;
		logic [15:0] freq_level_second_setting;
		logic [15:0] freq_level_third_setting;
		logic [15:0] freq_hysteresis_setting;
		logic [15:0] overload_level;
		logic [15:0] current_level_setting;
		logic [15:0] current_timer_setting;
		logic [15:0] current_level_second_setting;
		logic [15:0] current_timer_second_setting;
		logic [15:0] current_level_third_setting;
		logic [15:0] current_timer_third_setting;
		logic brake_fault_detect_disable;
	} dsf_cfg_t;
endpackage : dsf_pkg

/* File: dsf_level_timer.sv */
// module: level qualified for a timer, with minimum on time and a separate release condition
`timescale 1ns/1ps
`default_nettype none
module dsf_level_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic set_cond,
	input wire logic clear_cond,
	input wire logic [15:0] timer_ticks,
	output logic flag
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic [7:0] hold;
	logic [7:0] next_hold;
	logic next_flag;

	// count ticks while the set condition holds; release only after the minimum on time
	always_comb begin
		next_cnt = cnt;
		next_hold = hold;
		next_flag = flag;
		if (!set_cond) begin
			next_cnt = 16'h0000;
		end else if (tick && cnt < timer_ticks) begin
			next_cnt = cnt + 16'h0001;
		end
		if (tick && hold != 8'h00) begin
			next_hold = hold - 8'h01;
		end
		if (!flag && set_cond && cnt >= timer_ticks) begin
			next_flag = 1'b1;
			next_hold = 8'(dsf_pkg::MIN_ON_TICKS);
		end else if (flag && clear_cond && hold == 8'h00) begin
			next_flag = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= 16'h0000;
			hold <= 8'h00;
			flag <= 1'b0;
		end else begin
			cnt <= next_cnt;
			hold <= next_hold;
			flag <= next_flag;
		end
	end
endmodule : dsf_level_timer
`default_nettype wire

/* File: dsf_status_flags.sv */
// module: status-flag generator for assignable drive output terminals
`timescale 1ns/1ps
`default_nettype none
// Operation
// - four alarm-code outputs, assignments 90..93, weights one, two, four, eight
// - overcurrent group gives code one; overvoltage gives code two
// - undervoltage or phase loss gives three; motor overload gives four
// - drive overload gives five; overheat group gives six
// - external or resistor or motor overheat gives seven; memory-type errors give eight
// - communication errors nine, option errors ten, circuit failures eleven
// - tuning or output phase loss twelve; serial link errors thirteen
// - speed and encoder errors fourteen; other alarms fifteen
// - no active fault means all four code outputs off
// - light-fault flag follows light alarm, assignment 98
// - any-fault flag on when a protective function trips, assignment 99
// - enable circuit fault flag 101; enable terminal off flag 102
// - brake switch breakdown flag 105, detection can be disabled
// - assignments 111..120 route custom logic channels one to ten
// - arrival flags on when frequency error within arrival width
// - first arrival flag off when run off or reference zero
// - third arrival flag uses zero reference while run is off
// - delayed arrival uses pre-limit frequency, forced off, asserts after delay
// - arrival width 0.0..10.0 Hz, delay 0.01..10.00 s
// - frequency detect sets above level, clears below level minus hysteresis
// - three frequency detects, own levels, shared hysteresis, 0..500 Hz
// - overload uses own level; current-high flags own level and timer; current-low shares the second ones
// - current-high sets after timer, clears below 90 percent, 100 ms minimum
// - current-low sets after timer below level, clears above level plus 5 percent
// - overload warning sets above its level with no timer
module dsf_status_flags (
	input wire logic CLK,
	input wire logic RST,
	input wire dsf_pkg::dsf_fault_t FAULT,
	input wire dsf_pkg::dsf_meas_t MEAS,
	input wire dsf_pkg::dsf_cfg_t CFG,
	input wire logic [9:0] CUSTOM_LOGIC,
	input wire logic [39:0] TERMINAL_SELECT,
	output logic [3:0] FAULT_CODE,
	output logic LIGHT_FAULT_FLAG,
	output logic ANY_FAULT_FLAG,
	output logic ENABLE_CIRCUIT_FAULT_FLAG,
	output logic ENABLE_TERMINAL_OFF_FLAG,
	output logic BRAKE_SWITCH_FAULT_FLAG,
	output logic SPEED_ARRIVE_FLAG,
	output logic SPEED_ARRIVE_DELAYED_FLAG,
	output logic SPEED_ARRIVE_ZERO_REF_FLAG,
	output logic [2:0] FREQ_OVER_FLAGS,
	output logic OVERLOAD_WARNING_FLAG,
	output logic [2:0] CURRENT_HIGH_FLAGS,
	output logic CURRENT_LOW_FLAG,
	output logic [4:0] TERMINAL_OUT
);
	// internal registered flag state
	logic [3:0] fault_code;
	logic [3:0] next_fault_code;
	logic [4:0] simple_flags;
	logic [4:0] next_simple_flags;
	logic arrive;
	logic next_arrive;
	logic arrive_zero;
	logic next_arrive_zero;
	logic arrive_delayed;
	logic next_arrive_delayed;
	logic [15:0] delay_cnt;
	logic [15:0] next_delay_cnt;
	logic [2:0] freq_over;
	logic [2:0] next_freq_over;
	logic overload;
	logic next_overload;
	logic [2:0] cur_high;
	logic cur_low;
	logic [4:0] term;
	logic [4:0] next_term;
	logic [19:0] tick_cnt;
	logic [19:0] next_tick_cnt;
	logic tick;
	logic next_tick;

	// combinational helpers
	logic [15:0] ref_eff;
	logic [15:0] diff_out;
	logic [15:0] diff_pre;
	logic [15:0] diff_zero;
	logic [15:0] width;
	logic [15:0] delay_ticks;
	logic [15:0] hyst;
	logic [15:0] freq_lvl [3];
	logic [15:0] cur_lvl [3];
	logic [15:0] cur_tmr [3];
	logic [2:0] cur_set;
	logic [2:0] cur_clr;
	logic low_set;
	logic low_clr;

	// clamp settings to their ranges so odd values cannot misbehave
	always_comb begin
		width = (CFG.arrive_width_setting > dsf_pkg::ARRIVE_WIDTH_MAX) ?
			dsf_pkg::ARRIVE_WIDTH_MAX : CFG.arrive_width_setting;
		delay_ticks = CFG.arrive_delay_setting;
		if (delay_ticks < dsf_pkg::ARRIVE_DELAY_MIN) begin
			delay_ticks = dsf_pkg::ARRIVE_DELAY_MIN;
		end else if (delay_ticks > dsf_pkg::ARRIVE_DELAY_MAX) begin
			delay_ticks = dsf_pkg::ARRIVE_DELAY_MAX;
		end
		hyst = (CFG.freq_hysteresis_setting > dsf_pkg::FREQ_SETTING_MAX) ?
			dsf_pkg::FREQ_SETTING_MAX : CFG.freq_hysteresis_setting;
		freq_lvl[0] = CFG.freq_level_setting;
		freq_lvl[1] = CFG.freq_level_second_setting;
		freq_lvl[2] = CFG.freq_level_third_setting;
		for (int i = 0; i < 3; i++) begin
			if (freq_lvl[i] > dsf_pkg::FREQ_SETTING_MAX) begin
				freq_lvl[i] = dsf_pkg::FREQ_SETTING_MAX;
			end
		end
		cur_lvl[0] = CFG.current_level_setting;
		cur_lvl[1] = CFG.current_level_second_setting;
		cur_lvl[2] = CFG.current_level_third_setting;
		cur_tmr[0] = CFG.current_timer_setting;
		cur_tmr[1] = CFG.current_timer_second_setting;
		cur_tmr[2] = CFG.current_timer_third_setting;
		for (int i = 0; i < 3; i++) begin
			if (cur_tmr[i] > dsf_pkg::CURRENT_TIMER_MAX) begin
				cur_tmr[i] = dsf_pkg::CURRENT_TIMER_MAX;
			end
		end
	end

	// frequency error magnitudes
	always_comb begin
		ref_eff = MEAS.run_cmd ? MEAS.ref_freq : 16'h0000;
		diff_out = (MEAS.out_freq > MEAS.ref_freq) ? MEAS.out_freq - MEAS.ref_freq :
			MEAS.ref_freq - MEAS.out_freq;
		diff_pre = (MEAS.pre_limit_freq > MEAS.ref_freq) ?
			MEAS.pre_limit_freq - MEAS.ref_freq : MEAS.ref_freq - MEAS.pre_limit_freq;
		diff_zero = (MEAS.out_freq > ref_eff) ? MEAS.out_freq - ref_eff :
			ref_eff - MEAS.out_freq;
	end

	// fault group encoding
	always_comb begin
		next_fault_code = dsf_pkg::CODE_NONE;
		if (FAULT.tripped) begin
			unique case (FAULT.group)
				dsf_pkg::DSF_GRP_OVERCURRENT: next_fault_code = dsf_pkg::CODE_OVERCURRENT;
				dsf_pkg::DSF_GRP_OVERVOLT: next_fault_code = dsf_pkg::CODE_OVERVOLT;
				dsf_pkg::DSF_GRP_UNDERVOLT: next_fault_code = dsf_pkg::CODE_UNDERVOLT;
				dsf_pkg::DSF_GRP_MOTOR_OVERLOAD: next_fault_code = dsf_pkg::CODE_MOTOR_OVERLOAD;
				dsf_pkg::DSF_GRP_DRIVE_OVERLOAD: next_fault_code = dsf_pkg::CODE_DRIVE_OVERLOAD;
				dsf_pkg::DSF_GRP_OVERHEAT: next_fault_code = dsf_pkg::CODE_OVERHEAT;
				dsf_pkg::DSF_GRP_EXT_ALARM: next_fault_code = dsf_pkg::CODE_EXT_ALARM;
				dsf_pkg::DSF_GRP_MEMORY: next_fault_code = dsf_pkg::CODE_MEMORY;
				dsf_pkg::DSF_GRP_COMM: next_fault_code = dsf_pkg::CODE_COMM;
				dsf_pkg::DSF_GRP_OPTION: next_fault_code = dsf_pkg::CODE_OPTION;
				dsf_pkg::DSF_GRP_CIRCUIT: next_fault_code = dsf_pkg::CODE_CIRCUIT;
				dsf_pkg::DSF_GRP_TUNING: next_fault_code = dsf_pkg::CODE_TUNING;
				dsf_pkg::DSF_GRP_SERIAL: next_fault_code = dsf_pkg::CODE_SERIAL;
				dsf_pkg::DSF_GRP_SPEED: next_fault_code = dsf_pkg::CODE_SPEED;
				dsf_pkg::DSF_GRP_OTHER: next_fault_code = dsf_pkg::CODE_OTHER;
				dsf_pkg::DSF_GRP_NONE: next_fault_code = dsf_pkg::CODE_NONE;
				// a tripped fault with an unknown group still reports as other
				default: next_fault_code = dsf_pkg::CODE_OTHER;
			endcase
		end
	end

	// single fault flags: light, any, enable circuit, enable off, brake switch
	always_comb begin
		next_simple_flags[0] = FAULT.light_alarm;
		next_simple_flags[1] = FAULT.tripped;
		next_simple_flags[2] = FAULT.enable_circuit_error;
		next_simple_flags[3] = !FAULT.enable_terminal_on;
		next_simple_flags[4] = FAULT.brake_switch_broken && !CFG.brake_fault_detect_disable;
	end

	// 10 ms tick for every timer in the block
	always_comb begin
		next_tick = 1'b0;
		next_tick_cnt = tick_cnt + 20'h00001;
		if (tick_cnt == 20'(dsf_pkg::TICK_CYCLES - 1)) begin
			next_tick_cnt = 20'h00000;
			next_tick = 1'b1;
		end
	end

	// speed arrival flags
	always_comb begin
		// arrival gated by run and nonzero reference
		next_arrive = MEAS.run_cmd && MEAS.ref_freq != 16'h0000 && diff_out <= width;
		// stays on near zero when stopped
		next_arrive_zero = diff_zero <= width;
		next_delay_cnt = delay_cnt;
		next_arrive_delayed = 1'b0;
		if (MEAS.run_cmd && MEAS.ref_freq != 16'h0000 && diff_pre <= width) begin
			if (delay_cnt >= delay_ticks) begin
				next_arrive_delayed = 1'b1;
			end else if (tick) begin
				next_delay_cnt = delay_cnt + 16'h0001;
			end
		end else begin
			next_delay_cnt = 16'h0000;
		end
	end

	// frequency detection with shared hysteresis
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			// set above level, clear below level minus hysteresis
			next_freq_over[i] = freq_over[i];
			if (MEAS.out_freq > freq_lvl[i]) begin
				next_freq_over[i] = 1'b1;
			end else if ({1'b0, MEAS.out_freq} + {1'b0, hyst} < {1'b0, freq_lvl[i]}) begin
				next_freq_over[i] = 1'b0;
			end
		end
		next_overload = MEAS.out_current > CFG.overload_level;
	end

	// current comparisons; 90 percent taken as current*10 < level*9
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			cur_set[i] = MEAS.out_current > cur_lvl[i];
			cur_clr[i] = ({4'h0, MEAS.out_current} * 20'h0000a) < ({4'h0, cur_lvl[i]} * 20'h00009);
		end
		// low current shares second level and timer
		low_set = MEAS.out_current < CFG.current_level_second_setting;
		low_clr = {1'b0, MEAS.out_current} >
			{1'b0, CFG.current_level_second_setting} + {1'b0, dsf_pkg::RATED_5PCT};
	end

	for (genvar g = 0; g < 3; g++) begin : gen_cur_high
		dsf_level_timer u_high (
			.clk(CLK),
			.rst(RST),
			.tick(tick),
			.set_cond(cur_set[g]),
			.clear_cond(cur_clr[g]),
			.timer_ticks(cur_tmr[g]),
			.flag(cur_high[g])
		);
	end

	dsf_level_timer u_low (
		.clk(CLK),
		.rst(RST),
		.tick(tick),
		.set_cond(low_set),
		.clear_cond(low_clr),
		.timer_ticks(cur_tmr[1]),
		.flag(cur_low)
	);

	// terminal multiplexer; flags used are the registered ones, one cycle behind
	always_comb begin
		for (int t = 0; t < dsf_pkg::TERMINALS; t++) begin
			logic [7:0] sel;
			sel = TERMINAL_SELECT[t*8 +: 8];
			next_term[t] = 1'b0;
			// each terminal follows its assigned flag
			unique case (sel)
				dsf_pkg::SEL_SPEED_ARRIVE: next_term[t] = arrive;
				dsf_pkg::SEL_FREQ_OVER: next_term[t] = freq_over[0];
				dsf_pkg::SEL_OVERLOAD_WARN: next_term[t] = overload;
				dsf_pkg::SEL_ARRIVE_DELAYED: next_term[t] = arrive_delayed;
				dsf_pkg::SEL_FREQ_OVER_SECOND: next_term[t] = freq_over[1];
				dsf_pkg::SEL_CURRENT_HIGH: next_term[t] = cur_high[0];
				dsf_pkg::SEL_CURRENT_HIGH_SECOND: next_term[t] = cur_high[1];
				dsf_pkg::SEL_CURRENT_HIGH_THIRD: next_term[t] = cur_high[2];
				dsf_pkg::SEL_CURRENT_LOW: next_term[t] = cur_low;
				dsf_pkg::SEL_FREQ_OVER_THIRD: next_term[t] = freq_over[2];
				dsf_pkg::SEL_ARRIVE_ZERO_REF: next_term[t] = arrive_zero;
				dsf_pkg::SEL_CODE_W1: next_term[t] = fault_code[0];
				dsf_pkg::SEL_CODE_W2: next_term[t] = fault_code[1];
				dsf_pkg::SEL_CODE_W4: next_term[t] = fault_code[2];
				dsf_pkg::SEL_CODE_W8: next_term[t] = fault_code[3];
				dsf_pkg::SEL_LIGHT_FAULT: next_term[t] = simple_flags[0];
				dsf_pkg::SEL_ANY_FAULT: next_term[t] = simple_flags[1];
				dsf_pkg::SEL_ENABLE_CIRCUIT: next_term[t] = simple_flags[2];
				dsf_pkg::SEL_ENABLE_OFF: next_term[t] = simple_flags[3];
				dsf_pkg::SEL_BRAKE_SWITCH: next_term[t] = simple_flags[4];
				default: begin
					if (sel >= dsf_pkg::SEL_CUSTOM_FIRST && sel <= dsf_pkg::SEL_CUSTOM_LAST) begin
						next_term[t] = CUSTOM_LOGIC[4'(sel - dsf_pkg::SEL_CUSTOM_FIRST)];
					end
				end
			endcase
		end
	end

	// register every flag except the current ones; all other outputs come straight from these
	always_ff @(posedge CLK) begin
		if (RST) begin
			fault_code <= 4'h0;
			simple_flags <= 5'h00;
			arrive <= 1'b0;
			arrive_zero <= 1'b0;
			arrive_delayed <= 1'b0;
			delay_cnt <= 16'h0000;
			freq_over <= 3'h0;
			overload <= 1'b0;
			term <= 5'h00;
			tick_cnt <= 20'h00000;
			tick <= 1'b0;
		end else begin
			fault_code <= next_fault_code;
			simple_flags <= next_simple_flags;
			arrive <= next_arrive;
			arrive_zero <= next_arrive_zero;
			arrive_delayed <= next_arrive_delayed;
			delay_cnt <= next_delay_cnt;
			freq_over <= next_freq_over;
			overload <= next_overload;
			term <= next_term;
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
		end
	end

	assign FAULT_CODE = fault_code;
	assign LIGHT_FAULT_FLAG = simple_flags[0];
	assign ANY_FAULT_FLAG = simple_flags[1];
	assign ENABLE_CIRCUIT_FAULT_FLAG = simple_flags[2];
	assign ENABLE_TERMINAL_OFF_FLAG = simple_flags[3];
	assign BRAKE_SWITCH_FAULT_FLAG = simple_flags[4];
	assign SPEED_ARRIVE_FLAG = arrive;
	assign SPEED_ARRIVE_DELAYED_FLAG = arrive_delayed;
	assign SPEED_ARRIVE_ZERO_REF_FLAG = arrive_zero;
	assign FREQ_OVER_FLAGS = freq_over;
	assign OVERLOAD_WARNING_FLAG = overload;
	assign CURRENT_HIGH_FLAGS = cur_high;
	assign CURRENT_LOW_FLAG = cur_low;
	assign TERMINAL_OUT = term;
endmodule : dsf_status_flags
`default_nettype wire

/* File: dsf_terminal_reader.sv */
// partner model: machinery controller that latches the drive's output terminals
`timescale 1ns/1ps
`default_nettype none
module dsf_terminal_reader (
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] terminals,
	output logic [4:0] seen
);
	logic [4:0] next_seen;
	// one input register, so a flag is only believed a full cycle after the drive sets it
	always_comb begin
		next_seen = rst ? 5'h00 : terminals;
	end
	// register only
	always_ff @(posedge clk) begin
		seen <= next_seen;
	end
endmodule : dsf_terminal_reader
`default_nettype wire

/* File: dsf_status_flags_properties.sv */
// checker: timing relations between fault inputs, measurements and status flags
`timescale 1ns/1ps
`default_nettype none
module dsf_status_flags_chk (
	input wire logic CLK,
	input wire logic RST,
	input wire dsf_pkg::dsf_fault_t FAULT,
	input wire dsf_pkg::dsf_meas_t MEAS,
	input wire dsf_pkg::dsf_cfg_t CFG,
	input wire logic [39:0] TERMINAL_SELECT,
	input wire logic [3:0] FAULT_CODE,
	input wire logic LIGHT_FAULT_FLAG,
	input wire logic ANY_FAULT_FLAG,
	input wire logic ENABLE_TERMINAL_OFF_FLAG,
	input wire logic BRAKE_SWITCH_FAULT_FLAG,
	input wire logic SPEED_ARRIVE_FLAG,
	input wire logic SPEED_ARRIVE_DELAYED_FLAG,
	input wire logic [2:0] FREQ_OVER_FLAGS,
	input wire logic OVERLOAD_WARNING_FLAG,
	input wire logic [4:0] TERMINAL_OUT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// a tripped overvoltage fault
	sequence s_trip_ov;
		FAULT.tripped && FAULT.group == dsf_pkg::DSF_GRP_OVERVOLT;
	endsequence
	// trip routed to terminal 0 held long enough to pass both register stages
	sequence s_any_routed;
		(FAULT.tripped && TERMINAL_SELECT[7:0] == dsf_pkg::SEL_ANY_FAULT) [*2];
	endsequence
	AST_CODE_IDLE: assert property (!FAULT.tripped |=> FAULT_CODE == 4'h0)
		else $error("code not zero without trip");
	AST_CODE_OVERVOLT: assert property (s_trip_ov |=> FAULT_CODE == 4'h2)
		else $error("overvoltage code wrong");
	AST_CODE_OTHER: assert property ((FAULT.tripped && FAULT.group == dsf_pkg::DSF_GRP_OTHER)
		|=> FAULT_CODE == 4'hf) else $error("other alarm code wrong");
	AST_ANY_FAULT: assert property (1'b1 |=> ANY_FAULT_FLAG == $past(FAULT.tripped))
		else $error("any fault flag does not follow trip");
	AST_LIGHT: assert property (1'b1 |=> LIGHT_FAULT_FLAG == $past(FAULT.light_alarm))
		else $error("light fault flag does not follow alarm");
	AST_EN_OFF: assert property (!FAULT.enable_terminal_on |=> ENABLE_TERMINAL_OFF_FLAG)
		else $error("enable off flag missing");
	AST_BRAKE_OFF: assert property (CFG.brake_fault_detect_disable |=> !BRAKE_SWITCH_FAULT_FLAG)
		else $error("brake flag despite disable");
	AST_ARRIVE_FORCED: assert property ((!MEAS.run_cmd || MEAS.ref_freq == 16'h0000)
		|=> !SPEED_ARRIVE_FLAG && !SPEED_ARRIVE_DELAYED_FLAG) else $error("arrival not forced off");
	AST_FREQ_SET: assert property (MEAS.out_freq > CFG.freq_level_setting |=> FREQ_OVER_FLAGS[0])
		else $error("frequency detect not set");
	// settings above the clamp are left out, the clamped level would hold the flag
	AST_FREQ_CLEAR: assert property ((CFG.freq_level_setting <= 16'h1388 &&
		CFG.freq_hysteresis_setting <= 16'h1388 && {1'b0, MEAS.out_freq} +
		{1'b0, CFG.freq_hysteresis_setting} < {1'b0, CFG.freq_level_setting})
		|=> !FREQ_OVER_FLAGS[0]) else $error("frequency detect not cleared");
	AST_OVERLOAD: assert property (MEAS.out_current > CFG.overload_level |=> OVERLOAD_WARNING_FLAG)
		else $error("overload warning missing");
	AST_TERM_ROUTE: assert property (s_any_routed |=> TERMINAL_OUT[0])
		else $error("terminal not driven by selected flag");
endmodule : dsf_status_flags_chk
bind dsf_status_flags dsf_status_flags_chk i_chk (.CLK, .RST, .FAULT, .MEAS, .CFG,
	.TERMINAL_SELECT, .FAULT_CODE, .LIGHT_FAULT_FLAG, .ANY_FAULT_FLAG,
	.ENABLE_TERMINAL_OFF_FLAG, .BRAKE_SWITCH_FAULT_FLAG, .SPEED_ARRIVE_FLAG,
	.SPEED_ARRIVE_DELAYED_FLAG, .FREQ_OVER_FLAGS, .OVERLOAD_WARNING_FLAG, .TERMINAL_OUT);
`default_nettype wire

/* File: dsf_status_flags_tb.sv */
// testbench: fault codes, simple flags, routing and comparator scenarios
`timescale 1ns/1ps
`default_nettype none
module dsf_status_flags_tb;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	dsf_pkg::dsf_fault_t flt = '0;
	dsf_pkg::dsf_meas_t ms = '0;
	dsf_pkg::dsf_cfg_t cfg = '0;
	logic [9:0] cust = 10'h000;
	logic [39:0] sel = 40'h0000000000;
	logic [3:0] code;
	logic lf, af, ecf, eof, bsf, sa, sad, saz, olw, cl;
	logic [2:0] fo, ch;
	logic [4:0] tout, seen;
	int failures = 0;
	int tests_run = 0;
	// clock
	always #5 CLK = ~CLK;
	dsf_status_flags i_dut (.CLK(CLK), .RST(RST), .FAULT(flt), .MEAS(ms), .CFG(cfg),
		.CUSTOM_LOGIC(cust), .TERMINAL_SELECT(sel), .FAULT_CODE(code), .LIGHT_FAULT_FLAG(lf),
		.ANY_FAULT_FLAG(af), .ENABLE_CIRCUIT_FAULT_FLAG(ecf), .ENABLE_TERMINAL_OFF_FLAG(eof),
		.BRAKE_SWITCH_FAULT_FLAG(bsf), .SPEED_ARRIVE_FLAG(sa), .SPEED_ARRIVE_DELAYED_FLAG(sad),
		.SPEED_ARRIVE_ZERO_REF_FLAG(saz), .FREQ_OVER_FLAGS(fo), .OVERLOAD_WARNING_FLAG(olw),
		.CURRENT_HIGH_FLAGS(ch), .CURRENT_LOW_FLAG(cl), .TERMINAL_OUT(tout));
	dsf_terminal_reader i_rdr (.clk(CLK), .rst(RST), .terminals(tout), .seen(seen));
	// compare helpers; case equality so an unknown never matches
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic chk_flag(input logic got, input logic exp, input string what);
		chk({7'h00, got}, {7'h00, exp}, what);
	endtask : chk_flag
	// four falling edges cover flag, terminal and controller register stages
	task automatic settle;
		repeat (4) @(negedge CLK);
	endtask : settle
	// groups one to fifteen in turn, then trip released with the group left at fifteen
	task automatic t_codes;
		sel = {dsf_pkg::SEL_CODE_W8, dsf_pkg::SEL_CODE_W4, dsf_pkg::SEL_CODE_W2,
			dsf_pkg::SEL_CODE_W1, dsf_pkg::SEL_ANY_FAULT};
		flt.tripped = 1'b1;
		for (int i = 1; i < 16; i++) begin
			flt.group = dsf_pkg::dsf_group_t'(i);
			settle();
			chk({4'h0, code}, 8'(i), "code");
			chk({3'h0, seen}, {3'h0, 4'(i), 1'b1}, "code terminals");
		end
		flt.tripped = 1'b0;
		settle();
		chk({4'h0, code}, 8'h00, "idle code");
		chk_flag(af, 1'b0, "any fault");
		chk({3'h0, seen}, 8'h00, "idle terminals");
		$display("t_codes done");
	endtask : t_codes
	// all conditions on, all off, then on with brake detection disabled
	task automatic t_simple;
		sel = {dsf_pkg::SEL_BRAKE_SWITCH, dsf_pkg::SEL_ENABLE_OFF, dsf_pkg::SEL_ENABLE_CIRCUIT,
			dsf_pkg::SEL_LIGHT_FAULT, 8'h00};
		for (int k = 0; k < 3; k++) begin
			flt.light_alarm = (k != 1);
			flt.enable_circuit_error = (k != 1);
			flt.enable_terminal_on = (k == 1);
			flt.brake_switch_broken = (k != 1);
			cfg.brake_fault_detect_disable = (k == 2);
			settle();
			chk_flag(lf, k != 1, "light");
			chk_flag(ecf, k != 1, "enable circuit");
			chk_flag(eof, k != 1, "enable off");
			chk_flag(bsf, k == 0, "brake");
			chk({3'h0, seen}, {3'h0, k == 0, k != 1, k != 1, k != 1, 1'b0}, "flag terminals");
		end
		$display("t_simple done");
	endtask : t_simple
	// channels one to five, then six to ten, ending on the last assignment value
	task automatic t_custom;
		cust = 10'h2a5;
		for (int k = 0; k < 10; k += 5) begin
			for (int t = 0; t < 5; t++) begin
				sel[8*t +: 8] = dsf_pkg::SEL_CUSTOM_FIRST + 8'(k + t);
			end
			settle();
			chk({3'h0, seen}, {3'h0, cust[k +: 5]}, "custom");
		end
		$display("t_custom done");
	endtask : t_custom
	// one arrival step; the delayed flag never gets a full tick here
	task automatic arr(input logic run, input logic [15:0] rf, o, w, input logic esa, esz);
		ms.run_cmd = run;
		ms.ref_freq = rf;
		ms.out_freq = o;
		ms.pre_limit_freq = o;
		cfg.arrive_width_setting = w;
		settle();
		chk_flag(sa, esa, "arrive");
		chk_flag(saz, esz, "arrive zero");
		chk_flag(sad, 1'b0, "arrive delayed");
	endtask : arr
	task automatic t_arrive;
		arr(1'b1, 16'h01f4, 16'h0208, 16'h001e, 1'b1, 1'b1);
		arr(1'b1, 16'h01f4, 16'h028a, 16'h00c8, 1'b0, 1'b0);
		arr(1'b1, 16'h0000, 16'h0014, 16'h001e, 1'b0, 1'b1);
		arr(1'b0, 16'h01f4, 16'h0014, 16'h001e, 1'b0, 1'b1);
		arr(1'b0, 16'h01f4, 16'h0028, 16'h001e, 1'b0, 1'b0);
		$display("t_arrive done");
	endtask : t_arrive
	// one frequency step against levels 100, 200, 300 Hz and 10 Hz hysteresis
	task automatic frq(input logic [15:0] o, input logic [2:0] exp);
		ms.out_freq = o;
		settle();
		chk({5'h00, fo}, {5'h00, exp}, "freq detect");
	endtask : frq
	task automatic t_freq;
		cfg.freq_level_setting = 16'h03e8;
		cfg.freq_level_second_setting = 16'h07d0;
		cfg.freq_level_third_setting = 16'h0bb8;
		cfg.freq_hysteresis_setting = 16'h0064;
		frq(16'h0000, 3'h0);
		frq(16'h03e8, 3'h0);
		frq(16'h03e9, 3'h1);
		frq(16'h03b6, 3'h1);
		frq(16'h0383, 3'h0);
		frq(16'h0bb9, 3'h7);
		frq(16'h0b86, 3'h7);
		frq(16'h0b53, 3'h3);
		$display("t_freq done");
	endtask : t_freq
	// one current step; timers at zero qualify on the next cycle
	task automatic cur(input logic [15:0] c, input logic [2:0] eh, input logic el, eo);
		ms.out_current = c;
		settle();
		chk({5'h00, ch}, {5'h00, eh}, "current high");
		chk_flag(cl, el, "current low");
		chk_flag(olw, eo, "overload");
	endtask : cur
	task automatic t_current;
		cfg.overload_level = 16'h0320;
		cfg.current_level_setting = 16'h01f4;
		cfg.current_level_second_setting = 16'h012c;
		cfg.current_level_third_setting = 16'h02bc;
		cur(16'h01f4, 3'h2, 1'b0, 1'b0);
		cur(16'h0321, 3'h7, 1'b0, 1'b1);
		cur(16'h0320, 3'h7, 1'b0, 1'b0);
		cur(16'h00c8, 3'h7, 1'b1, 1'b0);
		$display("t_current done");
	endtask : t_current
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	// main sequence
	initial begin
		repeat (6) @(posedge CLK);
		@(negedge CLK);
		RST = 1'b0;
		flt.enable_terminal_on = 1'b1;
		t_codes();
		t_simple();
		t_custom();
		t_arrive();
		t_freq();
		t_current();
		conclude();
	end
	// hang guard, far beyond the roughly 160 cycles the run needs
	initial begin
		#1000000;
		failures++;
		conclude();
	end
endmodule : dsf_status_flags_tb
`default_nettype wire
